// File: logic/cis_exec.sv
// Execute stage for a subset of the core's instructions: add and xor immediate,
// relative branches with delay slot and annulling forms, conditional traps,
// wait for interrupt, shadow set write and halfword byte swap.
// Assumes operands are read by the register file on the same clock and that the
// core takes result as registered one-cycle pulses, one result per accepted issue.
`include "cis_map.svh"

// Operation
// - No extension, floating point or coprocessor-2 instructions
// - Add immediate wraps, never overflows
// - Unconditional branch is equal-compare of zero
// - Branch always with link writes pc+8
// - Equal-likely branches or annuls next instruction
// - Nonnegative branch when sign clear
// - Nonnegative link branch always links
// - Annulling link branch links, branches or annuls
// - Annulling nonnegative branch, no link
// - Positive branch when sign clear, nonzero
// - Annulling positive branch else annul next
// - Nonpositive branch when sign set or zero
// - Signed greater-equal traps
// - Unsigned greater-equal traps
// - Signed less-than traps
// - Unsigned less-than traps
// - Not-equal traps
// - Wait stalls in low power until interrupt
// - Shadow write into previous shadow set
// - Swap bytes within each halfword
// - Xor with zero-extended immediate
module cis_exec (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire cis_pkg::cis_issue_t issue,
  input  wire logic               irq_pending,
  input  wire logic [3:0]         previous_shadow_set_field,
  output logic                    ready,
  output cis_pkg::cis_result_t    result
);
  import cis_pkg::*;

  cis_state_t  st_ff;
  cis_state_t  nxt_st;
  logic [5:0]  op;
  logic [4:0]  rs_f;
  logic [4:0]  rt_f;
  logic [4:0]  rd_f;
  logic [4:0]  sa_f;
  logic [5:0]  fn_f;
  logic [31:0] imm_s;
  logic [31:0] op2;
  logic [31:0] sum_w;
  logic [31:0] xor_w;
  logic [31:0] swap_w;
  logic [31:0] link_w;
  logic [31:0] target_w;
  logic        live;
  logic        is_branch;
  logic        take;
  logic        likely;
  logic        link;
  logic        trap_op;
  logic        trap_hit;
  logic        cop_unus;
  logic        resv;
  logic        wait_op;

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  assign op     = issue.instr[31:26];
  assign rs_f   = issue.instr[25:21];
  assign rt_f   = issue.instr[20:16];
  assign rd_f   = issue.instr[15:11];
  assign sa_f   = issue.instr[10:6];
  assign fn_f   = issue.instr[5:0];
  assign imm_s  = sext16(issue.instr[15:0]);
  assign ready  = (st_ff.mode == CIS_RUN);
  assign result = st_ff.res;
  // Annulled slots are accepted but leave no trace.
  assign live   = issue.valid && ready && !st_ff.annul_next;

  // Datapath values; unsigned add keeps only 32 bits so no overflow exists.
  assign sum_w    = issue.rs_val + imm_s;
  assign xor_w    = issue.rs_val ^ {16'h0000, issue.instr[15:0]};
  assign swap_w   = {issue.rt_val[23:16], issue.rt_val[31:24],
                     issue.rt_val[7:0], issue.rt_val[15:8]};
  assign link_w   = issue.pc + `CIS_LINK_OFS;
  assign target_w = issue.pc + `CIS_SLOT_OFS + {imm_s[29:0], 2'b00};
  // Immediate trap forms sign-extend, even for the unsigned compare.
  assign op2      = (op == `CIS_OP_REGIMM) ? imm_s : issue.rt_val;

  always_comb begin
    is_branch = 1'b0;
    take      = 1'b0;
    likely    = 1'b0;
    link      = 1'b0;
    trap_op   = 1'b0;
    trap_hit  = 1'b0;
    cop_unus  = 1'b0;
    resv      = 1'b0;
    wait_op   = 1'b0;
    case (op)
      `CIS_OP_BR_EQ, `CIS_OP_BR_EQ_ANN: begin
        is_branch = 1'b1;
        take      = (issue.rs_val == issue.rt_val);
        likely    = (op == `CIS_OP_BR_EQ_ANN);
      end
      `CIS_OP_BR_NONPOS: begin
        is_branch = 1'b1;
        take      = issue.rs_val[31] || (issue.rs_val == 32'h0000_0000);
      end
      `CIS_OP_BR_POS, `CIS_OP_BR_POS_ANN: begin
        is_branch = 1'b1;
        take      = !issue.rs_val[31] && (issue.rs_val != 32'h0000_0000);
        likely    = (op == `CIS_OP_BR_POS_ANN);
      end
      `CIS_OP_REGIMM: begin
        case (rt_f)
          `CIS_RI_BR_NONNEG, `CIS_RI_BR_NONNEG_ANN, `CIS_RI_BR_NONNEG_LINK, `CIS_RI_BR_NONNEG_LINK_ANN: begin
            is_branch = 1'b1;
            take      = !issue.rs_val[31];
            likely    = rt_f[1];
            link      = rt_f[4];
          end
          `CIS_RI_TRAP_SGE_IMM: begin
            trap_op  = 1'b1;
            trap_hit = $signed(issue.rs_val) >= $signed(op2);
          end
          `CIS_RI_TRAP_UGE_IMM: begin
            trap_op  = 1'b1;
            trap_hit = issue.rs_val >= op2;
          end
          `CIS_RI_TRAP_SLT_IMM: begin
            trap_op  = 1'b1;
            trap_hit = $signed(issue.rs_val) < $signed(op2);
          end
          `CIS_RI_TRAP_ULT_IMM: begin
            trap_op  = 1'b1;
            trap_hit = issue.rs_val < op2;
          end
          `CIS_RI_TRAP_NE_IMM: begin
            trap_op  = 1'b1;
            trap_hit = issue.rs_val != op2;
          end
          default: ;
        endcase
      end
      `CIS_OP_SPECIAL: begin
        case (fn_f)
          `CIS_FN_TRAP_SGE: begin
            trap_op  = 1'b1;
            trap_hit = $signed(issue.rs_val) >= $signed(op2);
          end
          `CIS_FN_TRAP_UGE: begin
            trap_op  = 1'b1;
            trap_hit = issue.rs_val >= op2;
          end
          `CIS_FN_TRAP_SLT: begin
            trap_op  = 1'b1;
            trap_hit = $signed(issue.rs_val) < $signed(op2);
          end
          `CIS_FN_TRAP_ULT: begin
            trap_op  = 1'b1;
            trap_hit = issue.rs_val < op2;
          end
          `CIS_FN_TRAP_NE: begin
            trap_op  = 1'b1;
            trap_hit = issue.rs_val != op2;
          end
          default: ;
        endcase
      end
      `CIS_OP_COP0: wait_op = issue.instr[25] && (fn_f == `CIS_FN_WAIT);
      // Loads and stores of the absent coprocessors live in other opcodes.
      `CIS_OP_COP1, `CIS_OP_COP1X, `CIS_OP_COP2: cop_unus = 1'b1;
      6'h31, 6'h35, 6'h39, 6'h3d, 6'h32, 6'h36, 6'h3a, 6'h3e: cop_unus = 1'b1;
      `CIS_OP_SPECIAL2: resv = (fn_f >= `CIS_UDI_LO) && (fn_f <= `CIS_UDI_HI);
      default: ;
    endcase
  end

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.res = '0;
    if (st_ff.mode == CIS_WAIT) begin
      nxt_st.res.low_power = 1'b1;
      if (irq_pending) begin
        nxt_st.mode          = CIS_RUN;
        nxt_st.res.low_power = 1'b0;
      end
    end else if (issue.valid && st_ff.annul_next) begin
      nxt_st.annul_next = 1'b0;
    end else if (live) begin
      // A pending branch transfers only after its delay slot has run.
      if (st_ff.br_pend) begin
        nxt_st.br_pend         = 1'b0;
        nxt_st.res.redirect    = 1'b1;
        nxt_st.res.redirect_pc = st_ff.br_target;
      end
      if (is_branch) begin
        if (take) begin
          nxt_st.br_pend   = 1'b1;
          nxt_st.br_target = target_w;
        end else if (likely) begin
          nxt_st.annul_next = 1'b1;
        end
        if (link) begin
          nxt_st.res.gpr_we   = 1'b1;
          nxt_st.res.gpr_addr = `CIS_LINK_REG;
          nxt_st.res.gpr_data = link_w;
        end
      end else if (trap_op) begin
        nxt_st.res.trap = trap_hit;
      end else if (cop_unus) begin
        nxt_st.res.cop_unusable = 1'b1;
        // Coprocessor-2 opcodes all end in binary 10; the extended coprocessor-1 opcode ends in 11.
        nxt_st.res.cop_num      = (op[1:0] == 2'b10) ? 2'h2 : 2'h1;
      end else if (resv) begin
        nxt_st.res.reserved_instr = 1'b1;
      end else if (wait_op) begin
        nxt_st.mode          = CIS_WAIT;
        nxt_st.res.low_power = 1'b1;
      end else if (op == `CIS_OP_ADD_IMM) begin
        nxt_st.res.gpr_we   = 1'b1;
        nxt_st.res.gpr_addr = rt_f;
        nxt_st.res.gpr_data = sum_w;
      end else if (op == `CIS_OP_XOR_IMM) begin
        nxt_st.res.gpr_we   = 1'b1;
        nxt_st.res.gpr_addr = rt_f;
        nxt_st.res.gpr_data = xor_w;
      end else if (op == `CIS_OP_SPECIAL3 && fn_f == `CIS_FN_BSHFL && sa_f == `CIS_SA_HALF_SWAP) begin
        nxt_st.res.gpr_we   = 1'b1;
        nxt_st.res.gpr_addr = rd_f;
        nxt_st.res.gpr_data = swap_w;
      end else if (op == `CIS_OP_COP0 && rs_f == `CIS_RS_SHADOW_WR) begin
        nxt_st.res.sgpr_we  = 1'b1;
        nxt_st.res.sgpr_set = previous_shadow_set_field;
        nxt_st.res.gpr_addr = rd_f;
        nxt_st.res.gpr_data = issue.rt_val;
      end else begin
        nxt_st.res.passthru = 1'b1;
      end
      // An exception in the delay slot wins over the branch it follows.
      if (nxt_st.res.trap || nxt_st.res.cop_unusable || nxt_st.res.reserved_instr) begin
        nxt_st.res.redirect = 1'b0;
        nxt_st.br_pend      = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  chk_cop_refused:
  assert property (@(posedge clk) disable iff (rst)
    live && cop_unus |=> result.cop_unusable && !result.gpr_we && !result.redirect)
    else $error("coprocessor instruction was not refused");

  chk_add_wraps:
  assert property (@(posedge clk) disable iff (rst)
    live && op == `CIS_OP_ADD_IMM |=> result.gpr_we && !result.trap && result.gpr_addr == $past(rt_f)
      && result.gpr_data == $past(issue.rs_val) + {{16{$past(issue.instr[15])}}, $past(issue.instr[15:0])})
    else $error("add immediate result wrong");

  chk_link_value:
  assert property (@(posedge clk) disable iff (rst)
    live && is_branch && link |=> result.gpr_we && result.gpr_addr == `CIS_LINK_REG
      && result.gpr_data == $past(issue.pc) + `CIS_LINK_OFS)
    else $error("link register value wrong");

  chk_annul_slot:
  assert property (@(posedge clk) disable iff (rst)
    live && is_branch && likely && !take |=> st_ff.annul_next
      ##1 ($past(issue.valid) ? (!st_ff.annul_next && result == '0) : st_ff.annul_next))
    else $error("likely branch did not annul its slot");

  chk_delay_redirect:
  assert property (@(posedge clk) disable iff (rst)
    live && is_branch && take ##1 live && !cop_unus && !resv && !trap_hit
      |=> result.redirect && result.redirect_pc == $past(st_ff.br_target))
    else $error("branch did not redirect after its delay slot");

  chk_trap_flag:
  assert property (@(posedge clk) disable iff (rst)
    live && trap_op |=> result.trap == $past(trap_hit))
    else $error("trap outcome wrong");

  chk_wait_stall:
  assert property (@(posedge clk) disable iff (rst)
    st_ff.mode == CIS_WAIT && !irq_pending |=> !ready && result.low_power)
    else $error("wait released without interrupt");

  chk_shadow_write:
  assert property (@(posedge clk) disable iff (rst)
    live && op == `CIS_OP_COP0 && rs_f == `CIS_RS_SHADOW_WR
      |=> result.sgpr_we && result.sgpr_set == $past(previous_shadow_set_field) && !result.gpr_we)
    else $error("shadow write went to wrong set");

  chk_swap_bytes:
  assert property (@(posedge clk) disable iff (rst)
    live && op == `CIS_OP_SPECIAL3 && fn_f == `CIS_FN_BSHFL && sa_f == `CIS_SA_HALF_SWAP
      |=> result.gpr_we && result.gpr_addr == $past(rd_f)
        && {result.gpr_data[23:16], result.gpr_data[31:24], result.gpr_data[7:0], result.gpr_data[15:8]}
           == $past(issue.rt_val))
    else $error("halfword swap wrong");
endmodule

// File: logic/cis_map.svh
// Opcode and field constants for the instruction semantics block.
// Assumes the standard 32-bit fixed-width instruction word layout.
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH
`define CIS_OP_SPECIAL            6'h00
`define CIS_OP_REGIMM             6'h01
`define CIS_OP_BR_EQ              6'h04
`define CIS_OP_BR_NONPOS          6'h06
`define CIS_OP_BR_POS             6'h07
`define CIS_OP_ADD_IMM            6'h09
`define CIS_OP_XOR_IMM            6'h0e
`define CIS_OP_COP0               6'h10
`define CIS_OP_COP1               6'h11
`define CIS_OP_COP2               6'h12
`define CIS_OP_COP1X              6'h13
`define CIS_OP_BR_EQ_ANN          6'h14
`define CIS_OP_BR_POS_ANN         6'h17
`define CIS_OP_SPECIAL2           6'h1c
`define CIS_OP_SPECIAL3           6'h1f
`define CIS_RI_BR_NONNEG          5'h01
`define CIS_RI_BR_NONNEG_ANN      5'h03
`define CIS_RI_TRAP_SGE_IMM       5'h08
`define CIS_RI_TRAP_UGE_IMM       5'h09
`define CIS_RI_TRAP_SLT_IMM       5'h0a
`define CIS_RI_TRAP_ULT_IMM       5'h0b
`define CIS_RI_TRAP_NE_IMM        5'h0e
`define CIS_RI_BR_NONNEG_LINK     5'h11
`define CIS_RI_BR_NONNEG_LINK_ANN 5'h13
`define CIS_FN_TRAP_SGE           6'h30
`define CIS_FN_TRAP_UGE           6'h31
`define CIS_FN_TRAP_SLT           6'h32
`define CIS_FN_TRAP_ULT           6'h33
`define CIS_FN_TRAP_NE            6'h36
`define CIS_FN_WAIT               6'h20
`define CIS_FN_BSHFL              6'h20
`define CIS_SA_HALF_SWAP          5'h02
`define CIS_RS_SHADOW_WR          5'h0e
`define CIS_UDI_LO                6'h10
`define CIS_UDI_HI                6'h1f
`define CIS_LINK_REG              5'h1f
`define CIS_LINK_OFS              32'h0000_0008
`define CIS_SLOT_OFS              32'h0000_0004
`endif

// File: logic/cis_pkg.sv
// Types shared by the instruction semantics block and its users.
// Assumes one clock domain shared with fetch and the register file.
package cis_pkg;
  typedef enum logic {CIS_RUN, CIS_WAIT} cis_mode_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] rs_val;
    logic [31:0] rt_val;
  } cis_issue_t;

  typedef struct packed {
    logic        gpr_we;
    logic [4:0]  gpr_addr;
    logic [31:0] gpr_data;
    logic        sgpr_we;
    logic [3:0]  sgpr_set;
    logic        redirect;
    logic [31:0] redirect_pc;
    logic        trap;
    logic        cop_unusable;
    logic [1:0]  cop_num;
    logic        reserved_instr;
    logic        low_power;
    logic        passthru;
  } cis_result_t;

  typedef struct packed {
    cis_mode_t   mode;
    logic        annul_next;
    logic        br_pend;
    logic [31:0] br_target;
    cis_result_t res;
  } cis_state_t;
endpackage

// File: tb/cis_exec_tb.sv
// Self-checking bench for the instruction semantics execute stage.
// Assumes cis_pkg is compiled first and that each taken issue answers one cycle later.
module cis_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cis_pkg::*;

  logic        clk;
  logic        rst;
  cis_issue_t  issue;
  logic        irq_pending;
  logic [3:0]  shadow_sel;
  logic        ready;
  cis_result_t result;
  cis_result_t got;
  int          err_total;
  int          n_compared;

  cis_exec u_cis_exec (
    .clk                       (clk),
    .rst                       (rst),
    .issue                     (issue),
    .irq_pending               (irq_pending),
    .previous_shadow_set_field (shadow_sel),
    .ready                     (ready),
    .result                    (result)
  );

  always #20 clk = ~clk;

  function automatic logic [31:0] iw(input logic [5:0] op, input logic [4:0] rs, input logic [4:0] rt,
                                     input logic [15:0] imm);
    return {op, rs, rt, imm};
  endfunction

  function automatic logic [31:0] rw(input logic [5:0] op, input logic [4:0] rs, input logic [4:0] rt,
                                     input logic [4:0] rd, input logic [4:0] sa, input logic [5:0] fn);
    return {op, rs, rt, rd, sa, fn};
  endfunction

  function automatic cis_result_t wr(input logic [4:0] a, input logic [31:0] d);
    cis_result_t r;
    r = '0;
    r.gpr_we = 1'b1;
    r.gpr_addr = a;
    r.gpr_data = d;
    return r;
  endfunction

  function automatic cis_result_t tr(input int hit);
    cis_result_t r;
    r = '0;
    r.trap = (hit != 0);
    return r;
  endfunction

  function automatic cis_result_t cu(input int un, input logic [1:0] num, input int rsv);
    cis_result_t r;
    r = '0;
    r.cop_unusable = (un != 0);
    r.cop_num = num;
    r.reserved_instr = (rsv != 0);
    return r;
  endfunction

  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_res(input string nm, input cis_result_t e);
    n_compared++;
    if (got !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask

  // Issue is launched on the edge; got then shows what the previous edge's issue produced.
  task automatic cyc(input logic v, input logic [31:0] ins, input logic [31:0] pc, input logic [31:0] a,
                     input logic [31:0] b);
    @(posedge clk);
    issue <= '{v, ins, pc, a, b};
    #1;
    got = result;
  endtask

  task automatic one(input string nm, input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                     input cis_result_t e);
    cyc(1'b1, ins, 32'h0000_0200, a, b);
    cyc(1'b0, '0, '0, '0, '0);
    chk_res(nm, e);
  endtask

  task automatic t_alu;
    cis_result_t e;
    one("add wrap", iw(6'h09, 5'h01, 5'h02, 16'h0002), 32'hFFFF_FFFF, '0, wr(5'h02, 32'h0000_0001));
    one("add sext", iw(6'h09, 5'h01, 5'h03, 16'h8000), 32'h0000_0010, '0, wr(5'h03, 32'hFFFF_8010));
    one("xor imm", iw(6'h0e, 5'h01, 5'h04, 16'h8001), 32'hFFFF_0000, '0, wr(5'h04, 32'hFFFF_8001));
    one("swap", rw(6'h1f, 5'h00, 5'h05, 5'h06, 5'h02, 6'h20), '0, 32'h1122_3344,
        wr(5'h06, 32'h2211_4433));
    @(posedge clk);
    shadow_sel <= 4'h9;
    e = '0;
    e.sgpr_we = 1'b1;
    e.sgpr_set = 4'h9;
    e.gpr_addr = 5'h08;
    e.gpr_data = 32'h5A5A_0001;
    one("shadow write", rw(6'h10, 5'h0e, 5'h07, 5'h08, 5'h00, 6'h00), '0, 32'h5A5A_0001, e);
  endtask

  // Branch at 0x100 with offset -2 words, then an add in its delay slot.
  task automatic br_case(input string nm, input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                         input int tk, input int lnk, input int lk);
    cis_result_t e;
    cyc(1'b1, ins, 32'h0000_0100, a, b);
    cyc(1'b1, iw(6'h09, 5'h01, 5'h02, 16'h0005), 32'h0000_0104, 32'h0000_0001, '0);
    e = (lnk != 0) ? wr(5'h1f, 32'h0000_0108) : '0;
    chk_res({nm, " link"}, e);
    cyc(1'b0, '0, '0, '0, '0);
    e = (lk != 0 && tk == 0) ? '0 : wr(5'h02, 32'h0000_0006);
    e.redirect = (tk != 0);
    e.redirect_pc = (tk != 0) ? 32'h0000_00FC : '0;
    chk_res({nm, " slot"}, e);
  endtask

  task automatic t_branch;
    br_case("always", iw(6'h04, 5'h00, 5'h00, 16'hFFFE), '0, '0, 1, 0, 0);
    br_case("always link", iw(6'h01, 5'h00, 5'h11, 16'hFFFE), '0, '0, 1, 1, 0);
    br_case("equal differ", iw(6'h04, 5'h01, 5'h02, 16'hFFFE), 32'h0000_0001, 32'h0000_0002, 0, 0, 0);
    br_case("equal ann hit", iw(6'h14, 5'h01, 5'h02, 16'hFFFE), 32'h0000_0007, 32'h0000_0007, 1, 0, 1);
    br_case("equal ann miss", iw(6'h14, 5'h01, 5'h02, 16'hFFFE), 32'h0000_0007, 32'h0000_0008, 0, 0, 1);
    br_case("nonneg zero", iw(6'h01, 5'h01, 5'h01, 16'hFFFE), '0, '0, 1, 0, 0);
    br_case("nonneg neg", iw(6'h01, 5'h01, 5'h01, 16'hFFFE), 32'h8000_0000, '0, 0, 0, 0);
    br_case("link neg", iw(6'h01, 5'h01, 5'h11, 16'hFFFE), 32'hFFFF_FFFF, '0, 0, 1, 0);
    br_case("link pos", iw(6'h01, 5'h01, 5'h11, 16'hFFFE), 32'h7FFF_FFFF, '0, 1, 1, 0);
    br_case("link ann neg", iw(6'h01, 5'h01, 5'h13, 16'hFFFE), 32'h8000_0000, '0, 0, 1, 1);
    br_case("link ann pos", iw(6'h01, 5'h01, 5'h13, 16'hFFFE), 32'h0000_0001, '0, 1, 1, 1);
    br_case("nonneg ann neg", iw(6'h01, 5'h01, 5'h03, 16'hFFFE), 32'h8000_0000, '0, 0, 0, 1);
    br_case("nonneg ann zero", iw(6'h01, 5'h01, 5'h03, 16'hFFFE), '0, '0, 1, 0, 1);
    br_case("pos zero", iw(6'h07, 5'h01, 5'h00, 16'hFFFE), '0, '0, 0, 0, 0);
    br_case("pos one", iw(6'h07, 5'h01, 5'h00, 16'hFFFE), 32'h0000_0001, '0, 1, 0, 0);
    br_case("pos ann zero", iw(6'h17, 5'h01, 5'h00, 16'hFFFE), '0, '0, 0, 0, 1);
    br_case("pos ann one", iw(6'h17, 5'h01, 5'h00, 16'hFFFE), 32'h0000_0001, '0, 1, 0, 1);
    br_case("nonpos zero", iw(6'h06, 5'h01, 5'h00, 16'hFFFE), '0, '0, 1, 0, 0);
    br_case("nonpos neg", iw(6'h06, 5'h01, 5'h00, 16'hFFFE), 32'h8000_0000, '0, 1, 0, 0);
    br_case("nonpos one", iw(6'h06, 5'h01, 5'h00, 16'hFFFE), 32'h0000_0001, '0, 0, 0, 0);
  endtask

  // Apart from the equal and not-equal cases, operands straddle the sign bit so signed and unsigned compares disagree.
  task automatic t_trap;
    one("tr s ge", rw(6'h00, 5'h01, 5'h02, 5'h00, 5'h00, 6'h30), 32'hFFFF_FFFF, 32'h0000_0001, tr(0));
    one("tr s ge eq", rw(6'h00, 5'h01, 5'h02, 5'h00, 5'h00, 6'h30), 32'h0000_0005, 32'h0000_0005, tr(1));
    one("tr s ge imm", iw(6'h01, 5'h01, 5'h08, 16'hFFFF), '0, '0, tr(1));
    one("tr u ge", rw(6'h00, 5'h01, 5'h02, 5'h00, 5'h00, 6'h31), 32'hFFFF_FFFF, 32'h0000_0001, tr(1));
    one("tr u ge imm", iw(6'h01, 5'h01, 5'h09, 16'hFFFF), '0, '0, tr(0));
    one("tr s lt", rw(6'h00, 5'h01, 5'h02, 5'h00, 5'h00, 6'h32), 32'hFFFF_FFFF, 32'h0000_0001, tr(1));
    one("tr s lt imm", iw(6'h01, 5'h01, 5'h0a, 16'h0000), 32'h8000_0000, '0, tr(1));
    one("tr u lt", rw(6'h00, 5'h01, 5'h02, 5'h00, 5'h00, 6'h33), 32'hFFFF_FFFF, 32'h0000_0001, tr(0));
    one("tr u lt imm", iw(6'h01, 5'h01, 5'h0b, 16'hFFFF), 32'h0000_0001, '0, tr(1));
    one("tr ne same", rw(6'h00, 5'h01, 5'h02, 5'h00, 5'h00, 6'h36), 32'h0000_0003, 32'h0000_0003, tr(0));
    one("tr ne diff", rw(6'h00, 5'h01, 5'h02, 5'h00, 5'h00, 6'h36), 32'h0000_0003, 32'h0000_0004, tr(1));
    one("tr ne imm", iw(6'h01, 5'h01, 5'h0e, 16'hFFFF), 32'hFFFF_FFFF, '0, tr(0));
  endtask

  task automatic t_unsup;
    cis_result_t e;
    e = '0;
    e.passthru = 1'b1;
    one("cop one", 32'h4400_0000, '0, '0, cu(1, 2'h1, 0));
    one("cop two", 32'h4800_0000, '0, '0, cu(1, 2'h2, 0));
    one("cop one x", 32'h4C00_0000, '0, '0, cu(1, 2'h1, 0));
    one("extension", 32'h7000_0010, '0, '0, cu(0, 2'h0, 1));
    // A non-extension function under the same opcode must pass on to other units.
    one("other special2", 32'h7000_0002, '0, '0, e);
  endtask

  // An add offered during the stall must be refused and leave no trace.
  task automatic t_wait;
    cis_result_t e;
    int          i;
    e = '0;
    e.low_power = 1'b1;
    cyc(1'b1, 32'h4200_0020, 32'h0000_0300, '0, '0);
    cyc(1'b1, iw(6'h09, 5'h01, 5'h02, 16'h0001), 32'h0000_0304, '0, '0);
    chk_res("stall entry", e);
    chk_bit("ready in stall", 1'b0, ready);
    cyc(1'b0, '0, '0, '0, '0);
    chk_res("stall refuse", e);
    @(posedge clk);
    irq_pending <= 1'b1;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      if (ready === 1'b1) break;
    end
    if (ready !== 1'b1) begin
      err_total++;
      $display("Error stall exit expected 1 seen %b", ready);
    end else begin
      got = result;
      chk_res("stall exit", '0);
      @(posedge clk);
      irq_pending <= 1'b0;
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    issue = '0;
    irq_pending = 1'b0;
    shadow_sel = 4'h0;
    err_total = 0;
    n_compared = 0;
    got = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    got = result;
    chk_res("reset result", '0);
    chk_bit("reset ready", 1'b1, ready);
    t_alu();
    t_branch();
    t_trap();
    t_unsup();
    t_wait();
    final_report();
  end
endmodule
